// ==== hw/spi_eeprom_cmd_protect.sv ====
module spi_eeprom_cmd_protect
  import spi_prot_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF,
  parameter int PAGE_BYTES = PAGE_BYTES_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  output logic o_miso,
  output logic o_miso_oe_n,
  output logic o_standby,
  output logic o_busy,
  output logic [7:0] o_status,
  output logic o_hw_lock,
  output logic o_sw_lock,
  output logic o_prog_start,
  output logic [ADDR_W-1:0] o_prog_addr,
  output logic [7:0] o_prog_len
);

  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  if (WRITE_CYCLES < WRITE_CYCLES_MIN || PAGE_BYTES < 1 || PAGE_BYTES > 255) begin : g_bad_param
    $error("Unsupported WRITE_CYCLES or PAGE_BYTES value.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side: runs on the serial clock, only while a frame is in progress.
  logic rst_link_n;
  logic armed_q;
  logic [2:0] bit_q;
  logic [6:0] shift_q;
  logic [7:0] byte_in;
  link_state_e state_q;
  link_state_e next_cmd;
  logic op_known;
  logic addr_hi_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] nbytes_q;
  logic [7:0] len_next;
  logic [7:0] tx_q;
  logic drive_q;
  logic miso_q;
  logic [7:0] stat_s1_q;
  logic [7:0] stat_s2_q;
  commit_s req_q;
  logic set_tgl_q;
  logic clr_tgl_q;
  logic edge_ok;
  // deselect resets protocol
  // Protocol state is cleared whenever the device is deselected.
  assign rst_link_n = i_rst_n & ~i_cs_n;
  // pause gating
  // A low pause pin at a rising edge means it went low while the clock was low.
  assign edge_ok = i_hold_n;
  assign byte_in = {shift_q, i_mosi};

  // select edge arm
  // Only a real falling edge of select arms the protocol after power-on.
  always_ff @(negedge i_cs_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge i_sck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      bit_q <= 3'h0;
      shift_q <= 7'h00;
    end else if (edge_ok) begin
      bit_q <= bit_q + 3'h1;
      shift_q <= byte_in[6:0];
    end
  end

  always_comb begin
    next_cmd = ST_HALT;
    op_known = 1'b1;
    unique case (byte_in)
      OP_LATCH_SET, OP_LATCH_CLR: next_cmd = ST_HALT;
      OP_STAT_RD: next_cmd = ST_STAT_RD;
      OP_STAT_WR: next_cmd = ST_STAT_WR;
      OP_ARR_RD: next_cmd = stat_s2_q[BUSY_POS] ? ST_HALT : ST_RADDR;
      OP_ARR_WR: next_cmd = ST_WADDR;
      default: op_known = 1'b0;
    endcase
    if (!armed_q) begin
      next_cmd = ST_HALT;
    end
  end

  always_ff @(posedge i_sck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      state_q <= ST_CMD;
    end else if (edge_ok && bit_q == 3'h7) begin
      unique case (state_q)
        ST_CMD: state_q <= next_cmd;
        ST_STAT_WR: state_q <= ST_HALT;
        ST_RADDR: state_q <= addr_hi_q ? ST_RADDR : ST_HALT;
        ST_WADDR: state_q <= addr_hi_q ? ST_WADDR : ST_DATA;
        ST_HALT, ST_STAT_RD, ST_DATA: state_q <= state_q;
        default: state_q <= ST_HALT;
      endcase
    end
  end

  assign len_next = (nbytes_q == 8'(PAGE_BYTES)) ? nbytes_q : nbytes_q + 8'h01;
  always_ff @(posedge i_sck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      addr_hi_q <= 1'b1;
      addr_q <= '0;
      nbytes_q <= 8'h00;
    end else if (edge_ok && bit_q == 3'h7) begin
      if (state_q == ST_RADDR || state_q == ST_WADDR) begin
        addr_hi_q <= 1'b0;
        addr_q <= {addr_q[7:0], byte_in};
      end
      if (state_q == ST_DATA) begin
        nbytes_q <= len_next;
      end
    end
  end

  // Status byte crosses bit by bit; each bit is an independent level.
  always_ff @(posedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_s1_q <= 8'h00;
      stat_s2_q <= 8'h00;
    end else begin
      stat_s1_q <= o_status;
      stat_s2_q <= stat_s1_q;
    end
  end

  always_ff @(posedge i_sck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      tx_q <= 8'h00;
      drive_q <= 1'b0;
    end else if (edge_ok && bit_q == 3'h7) begin
      if ((state_q == ST_CMD && next_cmd == ST_STAT_RD) || state_q == ST_STAT_RD) begin
        tx_q <= stat_s2_q;
        drive_q <= 1'b1;
      end
    end
  end

  always_ff @(negedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      miso_q <= 1'b0;
    end else if (edge_ok) begin
      miso_q <= tx_q[3'h7 - bit_q];
    end
  end
  assign o_miso = miso_q;
  assign o_miso_oe_n = i_cs_n | ~i_hold_n | ~drive_q;
  // whole bytes only
  // A request survives the deselect only if no further edge outside a pause followed its last byte.
  always_ff @(posedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_q <= '{kind: REQ_NONE, data: 8'h00, addr: '0, len: 8'h00};
    end else if (!i_cs_n && edge_ok) begin
      if (bit_q == 3'h7 && state_q == ST_STAT_WR) begin
        req_q <= '{kind: REQ_STATUS, data: byte_in, addr: '0, len: 8'h00};
      end else if (bit_q == 3'h7 && state_q == ST_DATA) begin
        req_q <= '{kind: REQ_ARRAY, data: byte_in, addr: addr_q, len: len_next};
      end else begin
        req_q.kind <= REQ_NONE;
      end
    end
  end

  always_ff @(posedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      set_tgl_q <= 1'b0;
      clr_tgl_q <= 1'b0;
    end else if (!i_cs_n && edge_ok && bit_q == 3'h7 && state_q == ST_CMD && armed_q) begin
      if (byte_in == OP_LATCH_SET) begin
        set_tgl_q <= ~set_tgl_q;
      end
      if (byte_in == OP_LATCH_CLR) begin
        clr_tgl_q <= ~clr_tgl_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core side: protection, latch and programming cycle on the system clock.

  logic [1:0] cs_sync_q;
  logic cs_prev_q;
  logic [1:0] wp_sync_q;
  logic [1:0] tg_s1_q;
  logic [1:0] tg_s2_q;
  logic [1:0] tg_s3_q;
  logic frame_end;
  logic set_pulse;
  logic clr_pulse;
  logic latch_q;
  logic lock_q;
  logic [1:0] bp_q;
  logic busy_q;
  logic [CNT_W-1:0] cnt_q;
  logic done;
  req_kind_e job_q;
  logic [2:0] pend_q;
  logic prot_hit;
  logic status_ok;
  logic array_ok;
  logic start;
  logic hw_lock;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_sync_q <= 2'h3;
      cs_prev_q <= 1'b1;
      wp_sync_q <= 2'h3;
      tg_s1_q <= 2'h0;
      tg_s2_q <= 2'h0;
      tg_s3_q <= 2'h0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], i_cs_n};
      cs_prev_q <= cs_sync_q[1];
      wp_sync_q <= {wp_sync_q[0], i_wp_n};
      tg_s1_q <= {clr_tgl_q, set_tgl_q};
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
    end
  end

  // The link request is frozen once select is high, so reading it here is safe.
  assign frame_end = cs_sync_q[1] & ~cs_prev_q;
  assign set_pulse = tg_s2_q[0] ^ tg_s3_q[0];
  assign clr_pulse = tg_s2_q[1] ^ tg_s3_q[1];
  assign hw_lock = lock_q & ~wp_sync_q[1];
  always_comb begin
    unique case (bp_q)
      BP_NONE: prot_hit = 1'b0;
      BP_QUARTER: prot_hit = req_q.addr >= QUARTER_BASE;
      BP_HALF: prot_hit = req_q.addr >= HALF_BASE;
      default: prot_hit = 1'b1;
    endcase
  end
  assign status_ok = req_q.kind == REQ_STATUS && latch_q && !busy_q && !hw_lock;
  assign array_ok = req_q.kind == REQ_ARRAY && latch_q && !busy_q && !prot_hit;
  assign start = frame_end & (status_ok | array_ok);
  assign done = busy_q && cnt_q == CNT_W'(WRITE_CYCLES - 1);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      job_q <= REQ_NONE;
      pend_q <= NV_RESET;
    end else if (start) begin
      busy_q <= 1'b1;
      cnt_q <= '0;
      job_q <= req_q.kind;
      pend_q <= {req_q.data[STAT_LOCK_POS], req_q.data[BP_HI_POS], req_q.data[BP_LO_POS]};
    end else if (done) begin
      busy_q <= 1'b0;
      job_q <= REQ_NONE;
    end else if (busy_q) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {lock_q, bp_q} <= NV_RESET;
    end else if (done && job_q == REQ_STATUS) begin
      {lock_q, bp_q} <= pend_q;
    end
  end

  // latch set and clear
  // A set arriving with a completion wins, so a fresh enable is never lost.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_q <= 1'b0;
    end else if (set_pulse) begin
      latch_q <= 1'b1;
    end else if (clr_pulse || done) begin
      latch_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prog_start <= 1'b0;
      o_prog_addr <= '0;
      o_prog_len <= 8'h00;
    end else begin
      o_prog_start <= frame_end & array_ok;
      if (frame_end && array_ok) begin
        o_prog_addr <= req_q.addr;
        o_prog_len <= req_q.len;
      end
    end
  end

  always_comb begin
    o_status = 8'h00;
    o_status[STAT_LOCK_POS] = lock_q;
    o_status[BP_HI_POS] = bp_q[1];
    o_status[BP_LO_POS] = bp_q[0];
    o_status[LATCH_POS] = latch_q;
    o_status[BUSY_POS] = busy_q;
  end
  assign o_standby = cs_sync_q[1] & ~busy_q;
  assign o_busy = busy_q;
  assign o_hw_lock = hw_lock;
  assign o_sw_lock = (bp_q != BP_NONE) & ~hw_lock;
  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence seq_start;
    start;
  endsequence
  sequence seq_busy_run;
    busy_q [*8];
  endsequence
  busy_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    seq_start |=> seq_busy_run) else $error("Busy did not stay high after start.");
  latch_need_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    seq_start |-> latch_q && !busy_q) else $error("Cycle started without latch.");
  hw_lock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (start && req_q.kind == REQ_STATUS) |-> !(lock_q && !wp_sync_q[1])) else $error("Locked status write.");
  prot_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (frame_end && req_q.kind == REQ_ARRAY && bp_q == 2'h3) |=> !o_prog_start) else $error("Protected write ran.");
  nv_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (busy_q && !done) |=> $stable(o_status[7:2])) else $error("Protect bits moved mid cycle.");
  latch_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (done && !set_pulse) |=> !o_status[LATCH_POS] && !o_status[BUSY_POS]) else $error("Latch kept after cycle.");
  latch_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $changed(set_tgl_q) |-> ##[2:4] o_status[LATCH_POS]) else $error("Latch set not executed.");
  float_desel_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_cs_n |-> o_miso_oe_n) else $error("Output driven while deselected.");
  bad_op_a: assert property (@(posedge i_sck) disable iff (!rst_link_n)
    (state_q == ST_CMD && bit_q == 3'h7 && edge_ok && !op_known) |=> state_q == ST_HALT)
    else $error("Unknown opcode not halted.");
  arm_gate_a: assert property (@(posedge i_sck) disable iff (!i_rst_n)
    !armed_q |=> $stable(set_tgl_q) && $stable(clr_tgl_q)) else $error("Command taken before arming.");
  late_edge_a: assert property (@(posedge i_sck) disable iff (!rst_link_n)
    (state_q == ST_HALT && edge_ok) |=> req_q.kind != REQ_STATUS) else $error("Late status write kept.");
endmodule

// ==== hw/spi_prot_pkg.sv ====
package spi_prot_pkg;

  // Instruction bytes.
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARR_RD = 8'h03;
  localparam logic [7:0] OP_ARR_WR = 8'h02;

  // Field positions inside protect_status_byte.
  localparam int STAT_LOCK_POS = 7;
  localparam int BP_HI_POS = 3;
  localparam int BP_LO_POS = 2;
  localparam int LATCH_POS = 1;
  localparam int BUSY_POS = 0;

  // Nonvolatile bits {status_lock_bit, block_protect_hi, block_protect_lo} at reset.
  localparam logic [2:0] NV_RESET = 3'h0;

  // Block protection boundaries.
  localparam int ADDR_W = 16;
  localparam logic [15:0] QUARTER_BASE = 16'hC000;
  localparam logic [15:0] HALF_BASE = 16'h8000;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;

  // Page size and programming time.
  localparam int PAGE_BYTES_DEF = 128;
  localparam int CLK_FREQ_MHZ = 125;
  localparam int TW_MS = 10;
  localparam int WRITE_CYCLES_DEF = TW_MS * 1000 * CLK_FREQ_MHZ;
  localparam int WRITE_CYCLES_MIN = 16;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_HALT,
    ST_STAT_RD,
    ST_STAT_WR,
    ST_RADDR,
    ST_WADDR,
    ST_DATA
  } link_state_e;

  typedef enum logic [1:0] {
    REQ_NONE,
    REQ_STATUS,
    REQ_ARRAY
  } req_kind_e;

  typedef struct packed {
    req_kind_e kind;
    logic [7:0] data;
    logic [ADDR_W-1:0] addr;
    logic [7:0] len;
  } commit_s;

endpackage

// ==== verif/spi_master_model.sv ====
module spi_master_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi,
  output logic o_hold_n,
  input wire logic i_miso,
  input wire logic i_miso_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic oe_seen;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_hold_n = 1'b1;
    oe_seen = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  task automatic frame(input int n, input logic [39:0] b, input int hold_at, output logic [15:0] rx);
    rx = 16'h0000;
    oe_seen = 1'b0;
    o_cs_n = 1'b0;
    #12;
    for (int i = 0; i < n; i++) begin
      if (i == hold_at) begin
        o_hold_n = 1'b0;
        repeat (4) begin
          o_mosi = ~o_mosi;
          #6 o_sck = 1'b1;
          #6 o_sck = 1'b0;
        end
        o_hold_n = 1'b1;
        #6;
      end
      o_mosi = b[39-i];
      #6 o_sck = 1'b1;
      // A floating output reads back inverted, so a stale level never passes for data.
      rx = {rx[14:0], (i_miso_oe_n === 1'b0) ? i_miso : ~i_miso};
      if (i_miso_oe_n === 1'b0) oe_seen = 1'b1;
      #6 o_sck = 1'b0;
    end
    #6 o_cs_n = 1'b1;
    // The released data line toggles so a stale level is never mistaken for data.
    o_mosi = ~o_mosi;
    #200;
  endtask
endmodule

// ==== verif/testbench.sv ====
module testbench;
  import spi_prot_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WCYC = 200;
  logic i_clk, i_rst_n, i_wp_n, sck, cs_n, mosi, hold_n;
  logic miso, miso_oe_n, standby, busy, hw_lock, sw_lock, prog_start;
  logic [7:0] status, prog_len, last_len;
  logic [ADDR_W-1:0] prog_addr, last_addr;
  logic [15:0] rx;
  int n_mismatch, checked, n_prog, p0;

  spi_master_model master_u (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .o_hold_n(hold_n),
    .i_miso(miso), .i_miso_oe_n(miso_oe_n));

  spi_eeprom_cmd_protect #(.WRITE_CYCLES(WCYC), .PAGE_BYTES(PAGE_BYTES_DEF)) dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi),
    .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_miso(miso), .o_miso_oe_n(miso_oe_n),
    .o_standby(standby), .o_busy(busy), .o_status(status), .o_hw_lock(hw_lock),
    .o_sw_lock(sw_lock), .o_prog_start(prog_start), .o_prog_addr(prog_addr), .o_prog_len(prog_len));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  always @(negedge i_clk) begin
    if (prog_start === 1'b1) begin
      n_prog++;
      last_addr = prog_addr;
      last_len = prog_len;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic op8(input logic [7:0] b);
    master_u.frame(8, {b, 32'h0}, -1, rx);
  endtask

  task automatic status_read_cmd();
    master_u.frame(24, {OP_STAT_RD, 32'h0}, -1, rx);
  endtask

  task automatic status_write_cmd(input logic [7:0] b);
    master_u.frame(16, {OP_STAT_WR, b, 24'h0}, -1, rx);
  endtask

  task automatic awr(input int n, input logic [15:0] a);
    master_u.frame(n, {OP_ARR_WR, a, 16'hA55A}, -1, rx);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 4000) begin
      @(negedge i_clk);
      k++;
    end
    if (k == 4000) begin
      n_mismatch++;
      $display("wrong value busy expected 0 seen 1");
      report_and_stop();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    checked = 0;
    n_prog = 0;
    i_rst_n = 1'b0;
    i_wp_n = 1'b1;
    repeat (12) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    check("status", {8'h00, status}, 16'h0000);
    check("oe_n", {15'h0, miso_oe_n}, 16'h0001);
    check("standby", {15'h0, standby}, 16'h0001);
    status_read_cmd();
    check("status_read_cmd", rx, 16'h0000);
    $display("reset test done");

    op8(OP_LATCH_SET);
    check("latch", {8'h00, status}, 16'h0002);
    status_read_cmd();
    check("status_read_cmd", rx, 16'h0202);
    check("oe seen", {15'h0, master_u.oe_seen}, 16'h0001);
    op8(OP_LATCH_CLR);
    check("latch", {8'h00, status}, 16'h0000);
    status_write_cmd(8'h8C);
    check("busy", {15'h0, busy}, 16'h0000);
    master_u.frame(8, {OP_LATCH_SET, 32'h0}, 4, rx);
    check("paused", {8'h00, status}, 16'h0002);
    master_u.frame(17, {OP_STAT_WR, 8'h8C, 24'h0}, -1, rx);
    check("busy", {15'h0, busy}, 16'h0000);
    status_write_cmd(8'h8C);
    check("busy", {15'h0, busy}, 16'h0001);
    check("standby", {15'h0, standby}, 16'h0000);
    status_read_cmd();
    check("status_read_cmd busy", rx, 16'h0303);
    wait_idle();
    check("status", {8'h00, status}, 16'h008C);
    $display("status write test done");

    @(negedge i_clk);
    i_wp_n = 1'b0;
    repeat (4) @(negedge i_clk);
    check("hw lock", {15'h0, hw_lock}, 16'h0001);
    op8(OP_LATCH_SET);
    status_write_cmd(8'h00);
    check("status", {8'h00, status}, 16'h008E);
    p0 = n_prog;
    awr(40, 16'h0000);
    check("prog", 16'(n_prog - p0), 16'h0000);
    @(negedge i_clk);
    i_wp_n = 1'b1;
    repeat (4) @(negedge i_clk);
    check("locks", {14'h0, hw_lock, sw_lock}, 16'h0001);
    status_write_cmd(8'h84);
    wait_idle();
    check("status", {8'h00, status}, 16'h0084);
    $display("protect test done");

    op8(OP_LATCH_SET);
    awr(40, 16'hC000);
    check("prog", 16'(n_prog - p0), 16'h0000);
    awr(36, 16'h0000);
    check("prog", 16'(n_prog - p0), 16'h0000);
    awr(40, 16'hBFFF);
    check("prog", 16'(n_prog - p0), 16'h0001);
    check("addr", last_addr, 16'hBFFF);
    check("len", {8'h00, last_len}, 16'h0002);
    wait_idle();
    check("status", {8'h00, status}, 16'h0084);
    master_u.frame(24, {8'hFF, 32'h0}, -1, rx);
    check("oe seen", {15'h0, master_u.oe_seen}, 16'h0000);
    op8(OP_LATCH_SET);
    status_read_cmd();
    check("status_read_cmd", rx, 16'h8686);
    $display("array test done");

    // Select already low when reset lets go: the frame must be ignored.
    @(negedge i_clk);
    i_rst_n = 1'b0;
    fork
      master_u.frame(8, {OP_LATCH_SET, 32'h0}, -1, rx);
      begin
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
      end
    join
    check("unarmed", {8'h00, status}, 16'h0000);
    op8(OP_LATCH_SET);
    check("armed", {8'h00, status}, 16'h0002);
    $display("rearm test done");
    report_and_stop();
  end
endmodule
